// file: src/aotc_delay_line.v
`timescale 1ns/1ps
// Circular buffer written on every half-cycle tick, read at two fixed ages
module aotc_delay_line #(
  parameter WIDTH = 15,
  parameter ADDR_W = 7
) (
  input wire core_clk,
  input wire sys_rst,
  input wire tick,
  input wire [WIDTH-1:0] din,
  input wire [ADDR_W-1:0] age_a,
  input wire [ADDR_W-1:0] age_b,
  output wire [WIDTH-1:0] dout_a,
  output wire [WIDTH-1:0] dout_b
);
  reg [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];
  reg [ADDR_W-1:0] wptr;
  reg [ADDR_W:0] fill;
  wire [ADDR_W-1:0] addr_a;
  wire [ADDR_W-1:0] addr_b;

  assign addr_a = wptr - age_a;
  assign addr_b = wptr - age_b;
  // Entries never written read as empty so reset flushes the line
  assign dout_a = (fill > {1'b0, age_a}) ? mem[addr_a] : {WIDTH{1'b0}};
  assign dout_b = (fill > {1'b0, age_b}) ? mem[addr_b] : {WIDTH{1'b0}};

  always @(posedge core_clk) begin
    if (tick) begin
      mem[wptr] <= din;
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      wptr <= {ADDR_W{1'b0}};
      fill <= {(ADDR_W+1){1'b0}};
    end else if (tick) begin
      wptr <= wptr + 1'b1;
      if (!fill[ADDR_W]) begin
        fill <= fill + 1'b1;
      end
    end
  end
endmodule

// file: src/aotc_map.vh
`ifndef AOTC_MAP_VH
`define AOTC_MAP_VH

// Register byte offsets
`define AOTC_REG_CTRL 8'h00
`define AOTC_REG_STATUS 8'h04
`define AOTC_REG_IRQ_STATUS 8'h08
`define AOTC_REG_IRQ_MASK 8'h0c
`define AOTC_REG_GAIN_I 8'h10
`define AOTC_REG_GAIN_Q 8'h14
`define AOTC_REG_OFFS_I 8'h18
`define AOTC_REG_OFFS_Q 8'h1c

// Control fields
`define AOTC_CTRL_ECM 0
`define AOTC_CTRL_DEMUX 1
`define AOTC_CTRL_INTERLEAVE 2
`define AOTC_CTRL_LFS 3
`define AOTC_CTRL_RESET 4'h2

// Status fields
`define AOTC_ST_CAL 0
`define AOTC_ST_I_READY 1
`define AOTC_ST_Q_READY 2
`define AOTC_ST_DLY_SEL 3
`define AOTC_ST_OCLK_RST 4

// Interrupt fields
`define AOTC_IRQ_I_OOR 0
`define AOTC_IRQ_Q_OOR 1
`define AOTC_IRQ_CAL_DONE 2
`define AOTC_IRQ_I_WAKE 3
`define AOTC_IRQ_Q_WAKE 4

// Adjust reset values and code limits
`define AOTC_GAIN_UNITY 15'h4000
`define AOTC_OFFS_ZERO 13'h0000
`define AOTC_GAIN_SHIFT 14
`define AOTC_MID_CODE 18'sh00800
`define AOTC_MAX_CODE 18'sh00fff
`define AOTC_WORD_ONES 12'hfff
`define AOTC_WORD_ZERO 12'h000

// Latency in sampling clock cycles, doubled into half-cycle ticks
`define AOTC_LAT_PRI_CYC 34
`define AOTC_LAT_DLY_CYC 35

// Timing
`define AOTC_CLK_NS 10
`define AOTC_WAKE_NS 500
`define AOTC_WAKE_DES_NS 1000
`define AOTC_CAL_PIN_CYC 11'h500
`define AOTC_CAL_DELAY_SELECT_LOW 31'h01000000
`define AOTC_CAL_DELAY_SELECT_HIGH 31'h40000000
`define AOTC_CAL_CYC 31'h02719c40

`endif

// file: src/aotc_top.v
`timescale 1ns/1ps
`include "aotc_map.vh"
module aotc_top #(
  parameter CAL_DELAY_SELECT_LOW_CYC = `AOTC_CAL_DELAY_SELECT_LOW,
  parameter CAL_DELAY_SELECT_HIGH_CYC = `AOTC_CAL_DELAY_SELECT_HIGH,
  parameter CAL_CYC = `AOTC_CAL_CYC
) (
  input wire core_clk,
  input wire sys_rst,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg irq,
  input wire sample_clk,
  input wire [13:0] i_sample_in,
  input wire [13:0] q_sample_in,
  input wire i_power_down,
  input wire q_power_down,
  input wire cal_delay_select,
  input wire cal_request,
  input wire output_clock_reset,
  output reg [11:0] i_primary_bus,
  output reg [11:0] i_delayed_bus,
  output reg [11:0] q_primary_bus,
  output reg [11:0] q_delayed_bus,
  output reg i_output_clock,
  output reg q_output_clock,
  output reg i_out_of_range_flag,
  output reg q_out_of_range_flag,
  output reg cal_running
);
  localparam ST_DELAY = 2'b00;
  localparam ST_CAL = 2'b01;
  localparam ST_IDLE = 2'b10;
  localparam integer AGE_PRI = 2 * `AOTC_LAT_PRI_CYC;
  localparam integer AGE_DLY = 2 * `AOTC_LAT_DLY_CYC;
  localparam integer WAKE_CYC = `AOTC_WAKE_NS / `AOTC_CLK_NS;
  localparam integer WAKE_DES_CYC = `AOTC_WAKE_DES_NS / `AOTC_CLK_NS;

  // Gain, offset and clamp of one raw sample into {oor, word}
  function [12:0] aotc_convert;
    input [13:0] raw;
    input [14:0] gain;
    input [12:0] offs;
    input extended_control_mode;
    reg signed [29:0] prod;
    reg signed [17:0] offv;
    reg signed [17:0] code;
    begin
      prod = $signed(raw) * $signed({1'b0, (extended_control_mode ? gain : `AOTC_GAIN_UNITY)});
      offv = offs[12] ? -$signed({6'h00, offs[11:0]}) : $signed({6'h00, offs[11:0]});
      if (!extended_control_mode) begin
        offv = 18'sh00000;
      end
      code = $signed({{2{prod[29]}}, prod[29:`AOTC_GAIN_SHIFT]}) + offv + `AOTC_MID_CODE;
      if (code < 18'sh00000) begin
        aotc_convert = {1'b1, `AOTC_WORD_ZERO};
      end else if (code > `AOTC_MAX_CODE) begin
        aotc_convert = {1'b1, `AOTC_WORD_ONES};
      end else begin
        aotc_convert = {1'b0, code[11:0]};
      end
    end
  endfunction

  // Byte-lane masked write
  function [31:0] aotc_wmask;
    input [31:0] old;
    input [31:0] val;
    input [3:0] sel;
    integer k;
    begin
      aotc_wmask = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          aotc_wmask[8*k +: 8] = val[8*k +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  reg [1:0] clk_sync;
  reg clk_last;
  reg [13:0] i_raw_s1;
  reg [13:0] i_raw;
  reg [13:0] q_raw_s1;
  reg [13:0] q_raw;
  reg [4:0] pin_s1;
  reg [4:0] pin_s2;
  wire tick_rise;
  wire tick_fall;
  wire tick;
  wire pd_i;
  wire pd_q;
  wire dly_pin;
  wire cal_pin;
  wire oclk_rst;

  always @(posedge core_clk) begin
    clk_sync <= {clk_sync[0], sample_clk};
    clk_last <= clk_sync[1];
    i_raw_s1 <= i_sample_in;
    i_raw <= i_raw_s1;
    q_raw_s1 <= q_sample_in;
    q_raw <= q_raw_s1;
    pin_s1 <= {output_clock_reset, cal_request, cal_delay_select, q_power_down, i_power_down};
    pin_s2 <= pin_s1;
  end

  assign tick_rise = clk_sync[1] & ~clk_last;
  assign tick_fall = ~clk_sync[1] & clk_last;
  assign tick = tick_rise | tick_fall;
  assign pd_i = pin_s2[0];
  assign pd_q = pin_s2[1];
  assign dly_pin = pin_s2[2];
  assign cal_pin = pin_s2[3];
  assign oclk_rst = pin_s2[4];

  ////////////////////////////////////////////////////////////////////////////////
  // Register file
  reg [3:0] ctrl;
  reg [4:0] irq_status;
  reg [4:0] irq_mask;
  reg [14:0] gain_i;
  reg [14:0] gain_q;
  reg [12:0] offs_i;
  reg [12:0] offs_q;
  reg i_ready;
  reg q_ready;
  reg dly_sel;
  reg [4:0] irq_events;
  reg [31:0] next_rdata;
  wire wb_req;
  wire wb_wr;
  wire [31:0] wr_word;
  wire extended_control_mode;
  wire demux;
  wire interleave;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;
  assign extended_control_mode = ctrl[`AOTC_CTRL_ECM];
  assign demux = ctrl[`AOTC_CTRL_DEMUX];
  assign interleave = ctrl[`AOTC_CTRL_INTERLEAVE];

  always @* begin
    case (wb_adr_i)
      `AOTC_REG_CTRL: next_rdata = {28'h0000000, ctrl};
      `AOTC_REG_STATUS: next_rdata = {27'h0000000, oclk_rst, dly_sel, q_ready, i_ready, cal_running};
      `AOTC_REG_IRQ_STATUS: next_rdata = {27'h0000000, irq_status};
      `AOTC_REG_IRQ_MASK: next_rdata = {27'h0000000, irq_mask};
      `AOTC_REG_GAIN_I: next_rdata = {17'h00000, gain_i};
      `AOTC_REG_GAIN_Q: next_rdata = {17'h00000, gain_q};
      `AOTC_REG_OFFS_I: next_rdata = {19'h00000, offs_i};
      `AOTC_REG_OFFS_Q: next_rdata = {19'h00000, offs_q};
      default: next_rdata = 32'h00000000;
    endcase
  end

  assign wr_word = aotc_wmask(next_rdata, wb_dat_i, wb_sel_i);

  always @(posedge core_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl <= `AOTC_CTRL_RESET;
      irq_status <= 5'h00;
      irq_mask <= 5'h00;
      gain_i <= `AOTC_GAIN_UNITY;
      gain_q <= `AOTC_GAIN_UNITY;
      offs_i <= `AOTC_OFFS_ZERO;
      offs_q <= `AOTC_OFFS_ZERO;
      irq <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req & ~wb_we_i) ? next_rdata : 32'h00000000;
      // New events win over a simultaneous write-one clear
      if (wb_wr && wb_adr_i == `AOTC_REG_IRQ_STATUS) begin
        irq_status <= (irq_status & ~(wb_dat_i[4:0] & {5{wb_sel_i[0]}})) | irq_events;
      end else begin
        irq_status <= irq_status | irq_events;
      end
      irq <= |((irq_status | irq_events) & irq_mask);
      if (wb_wr) begin
        case (wb_adr_i)
          `AOTC_REG_CTRL: ctrl <= wr_word[3:0];
          `AOTC_REG_IRQ_MASK: irq_mask <= wr_word[4:0];
          `AOTC_REG_GAIN_I: gain_i <= wr_word[14:0];
          `AOTC_REG_GAIN_Q: gain_q <= wr_word[14:0];
          `AOTC_REG_OFFS_I: offs_i <= wr_word[12:0];
          `AOTC_REG_OFFS_Q: offs_q <= wr_word[12:0];
          default: ctrl <= ctrl;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Capture and conversion per channel; Q captures on the falling tick in interleave mode, I always on the rising tick
  reg [12:0] i_cur;
  reg [12:0] q_cur;
  reg i_par;
  reg q_par;
  wire i_cap;
  wire q_cap;
  wire [12:0] i_conv;
  wire [12:0] q_conv;
  wire [14:0] i_din;
  wire [14:0] q_din;
  wire [14:0] i_tap_p;
  wire [14:0] i_tap_d;
  wire [14:0] q_tap_p;
  wire [14:0] q_tap_d;

  assign i_cap = tick_rise;
  assign q_cap = interleave ? tick_fall : tick_rise;
  assign i_conv = aotc_convert(i_raw, gain_i, offs_i, extended_control_mode);
  assign q_conv = aotc_convert(q_raw, gain_q, offs_q, extended_control_mode);
  assign i_din = i_cap ? {1'b1, i_par, i_conv} : {1'b0, i_par, i_cur};
  assign q_din = q_cap ? {1'b1, q_par, q_conv} : {1'b0, q_par, q_cur};

  always @(posedge core_clk) begin
    if (sys_rst) begin
      i_cur <= 13'h0000;
      q_cur <= 13'h0000;
      i_par <= 1'b0;
      q_par <= 1'b0;
    end else begin
      if (i_cap) begin
        i_cur <= i_conv;
        i_par <= ~i_par;
      end
      if (q_cap) begin
        q_cur <= q_conv;
        q_par <= ~q_par;
      end
    end
  end

  aotc_delay_line #(.WIDTH(15), .ADDR_W(7)) u_i_line (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tick(tick),
    .din(i_din),
    .age_a(AGE_PRI[6:0]),
    .age_b(AGE_DLY[6:0]),
    .dout_a(i_tap_p),
    .dout_b(i_tap_d)
  );

  aotc_delay_line #(.WIDTH(15), .ADDR_W(7)) u_q_line (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tick(tick),
    .din(q_din),
    .age_a(AGE_PRI[6:0]),
    .age_b(AGE_DLY[6:0]),
    .dout_a(q_tap_p),
    .dout_b(q_tap_d)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Output buses
  wire i_upd_p;
  wire i_upd_d;
  wire q_upd_p;
  wire q_upd_d;

  // Primary takes even samples in demux, every sample otherwise
  assign i_upd_p = tick & i_tap_p[14] & (~demux | ~i_tap_p[13]) & i_ready;
  assign i_upd_d = tick & i_tap_d[14] & demux & i_tap_d[13] & i_ready;
  assign q_upd_p = tick & q_tap_p[14] & (~demux | ~q_tap_p[13]) & q_ready;
  assign q_upd_d = tick & q_tap_d[14] & demux & q_tap_d[13] & q_ready;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      i_primary_bus <= 12'h000;
      i_delayed_bus <= 12'h000;
      q_primary_bus <= 12'h000;
      q_delayed_bus <= 12'h000;
      i_out_of_range_flag <= 1'b0;
      q_out_of_range_flag <= 1'b0;
      i_output_clock <= 1'b0;
      q_output_clock <= 1'b0;
    end else begin
      if (!i_ready) begin
        i_primary_bus <= 12'h000;
        i_delayed_bus <= 12'h000;
        i_out_of_range_flag <= 1'b0;
      end else if (i_upd_p) begin
        i_primary_bus <= i_tap_p[11:0];
        i_out_of_range_flag <= i_tap_p[12];
      end else if (i_upd_d) begin
        i_delayed_bus <= i_tap_d[11:0];
        i_out_of_range_flag <= i_tap_d[12];
      end
      if (!demux) begin
        i_delayed_bus <= 12'h000;
        q_delayed_bus <= 12'h000;
      end
      if (!q_ready) begin
        q_primary_bus <= 12'h000;
        q_delayed_bus <= 12'h000;
        q_out_of_range_flag <= 1'b0;
      end else if (q_upd_p) begin
        q_primary_bus <= q_tap_p[11:0];
        q_out_of_range_flag <= q_tap_p[12];
      end else if (q_upd_d) begin
        q_delayed_bus <= q_tap_d[11:0];
        q_out_of_range_flag <= q_tap_d[12];
      end
      // Output clocks stop while their reset is held and restart in phase
      if (oclk_rst) begin
        i_output_clock <= 1'b0;
        q_output_clock <= 1'b0;
      end else begin
        if (i_upd_p | i_upd_d) begin
          i_output_clock <= ~i_output_clock;
        end
        if (q_upd_p | q_upd_d) begin
          q_output_clock <= ~q_output_clock;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wake-up after power-down
  reg [7:0] i_wake_cnt;
  reg [7:0] q_wake_cnt;
  wire [7:0] wake_lim;

  assign wake_lim = interleave ? WAKE_DES_CYC[7:0] : WAKE_CYC[7:0];

  always @(posedge core_clk) begin
    if (sys_rst || pd_i) begin
      i_wake_cnt <= 8'h00;
      i_ready <= 1'b0;
    end else if (!i_ready) begin
      i_wake_cnt <= i_wake_cnt + 8'h01;
      i_ready <= (i_wake_cnt + 8'h01 >= wake_lim);
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst || pd_q) begin
      q_wake_cnt <= 8'h00;
      q_ready <= 1'b0;
    end else if (!q_ready) begin
      q_wake_cnt <= q_wake_cnt + 8'h01;
      q_ready <= (q_wake_cnt + 8'h01 >= wake_lim);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Calibration sequencing
  reg [1:0] cal_state;
  reg [30:0] cal_cnt;
  reg [10:0] pin_low_cnt;
  reg [10:0] pin_high_cnt;
  reg strap_done;
  reg cal_done_evt;
  wire [30:0] dly_lim;
  wire cmd_cal;

  assign dly_lim = dly_sel ? CAL_DELAY_SELECT_HIGH_CYC[30:0] : CAL_DELAY_SELECT_LOW_CYC[30:0];
  assign cmd_cal = pin_high_cnt == `AOTC_CAL_PIN_CYC;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      cal_state <= ST_DELAY;
      cal_cnt <= 31'h00000000;
      pin_low_cnt <= 11'h000;
      pin_high_cnt <= 11'h000;
      strap_done <= 1'b0;
      dly_sel <= 1'b0;
      cal_running <= 1'b0;
      cal_done_evt <= 1'b0;
    end else begin
      cal_done_evt <= 1'b0;
      if (!strap_done) begin
        dly_sel <= dly_pin;
        strap_done <= 1'b1;
      end
      // Low then high, each counted in sampling cycles
      if (cmd_cal) begin
        pin_low_cnt <= 11'h000;
        pin_high_cnt <= 11'h000;
      end else if (tick_rise) begin
        if (!cal_pin) begin
          pin_high_cnt <= 11'h000;
          if (pin_low_cnt != `AOTC_CAL_PIN_CYC) begin
            pin_low_cnt <= pin_low_cnt + 11'h001;
          end
        end else if (pin_low_cnt == `AOTC_CAL_PIN_CYC) begin
          pin_high_cnt <= pin_high_cnt + 11'h001;
        end
      end
      case (cal_state)
        ST_DELAY: begin
          if (strap_done && tick_rise) begin
            cal_cnt <= cal_cnt + 31'h00000001;
            if (cal_cnt + 31'h00000001 >= dly_lim) begin
              cal_cnt <= 31'h00000000;
              cal_running <= 1'b1;
              cal_state <= ST_CAL;
            end
          end
        end
        ST_CAL: begin
          if (tick_rise) begin
            cal_cnt <= cal_cnt + 31'h00000001;
            if (cal_cnt + 31'h00000001 >= CAL_CYC) begin
              cal_cnt <= 31'h00000000;
              cal_running <= 1'b0;
              cal_done_evt <= 1'b1;
              cal_state <= ST_IDLE;
            end
          end
        end
        ST_IDLE: begin
          if (cmd_cal) begin
            cal_running <= 1'b1;
            cal_state <= ST_CAL;
          end
        end
        default: begin
          cal_state <= ST_IDLE;
          cal_running <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt events
  reg i_ready_d;
  reg q_ready_d;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      i_ready_d <= 1'b0;
      q_ready_d <= 1'b0;
    end else begin
      i_ready_d <= i_ready;
      q_ready_d <= q_ready;
    end
  end

  always @* begin
    irq_events = 5'h00;
    irq_events[`AOTC_IRQ_I_OOR] = i_upd_p ? i_tap_p[12] : (i_upd_d & i_tap_d[12]);
    irq_events[`AOTC_IRQ_Q_OOR] = q_upd_p ? q_tap_p[12] : (q_upd_d & q_tap_d[12]);
    irq_events[`AOTC_IRQ_CAL_DONE] = cal_done_evt;
    irq_events[`AOTC_IRQ_I_WAKE] = i_ready & ~i_ready_d;
    irq_events[`AOTC_IRQ_Q_WAKE] = q_ready & ~q_ready_d;
  end
endmodule

// file: verification/aotc_capture_model.sv
`timescale 1ns/1ps
// Capture side: pulses the output clock reset, then waits for resync
module aotc_capture_model #(
  parameter HOLD_CYC = 48,
  parameter RESYNC_CYC = 48
) (
  input wire core_clk,
  input wire start,
  output reg output_clock_reset,
  output reg busy
);
  integer cnt = 0;
  initial begin
    output_clock_reset = 1'b0;
    busy = 1'b0;
  end
  always @(posedge core_clk) begin
    if (start && !busy) begin
      busy <= 1'b1;
      output_clock_reset <= 1'b1;
      cnt <= 0;
    end else if (busy) begin
      cnt <= cnt + 1;
      if (cnt == HOLD_CYC - 1) output_clock_reset <= 1'b0;
      if (cnt == HOLD_CYC + RESYNC_CYC - 1) busy <= 1'b0;
    end
  end
endmodule

// file: verification/aotc_checker_assertions.sv
`timescale 1ns/1ps
// Bus handshake and output word checks at the top ports
module aotc_checker (
  input wire core_clk,
  input wire sys_rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire output_clock_reset,
  input wire [11:0] i_primary_bus,
  input wire [11:0] q_primary_bus,
  input wire i_output_clock,
  input wire q_output_clock,
  input wire i_out_of_range_flag,
  input wire q_out_of_range_flag
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence oclk_rst_held;
    output_clock_reset [*5];
  endsequence
  ////////////////////////////////////////////////////////////////
  ack_after_req_a: assert property (bus_req |=> wb_ack_o)
    else $error("ack missing after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  i_oor_word_a: assert property ($changed(i_primary_bus) && i_out_of_range_flag |->
    i_primary_bus == 12'h000 || i_primary_bus == 12'hfff) else $error("i flag on unclamped word");
  q_oor_word_a: assert property ($changed(q_primary_bus) && q_out_of_range_flag |->
    q_primary_bus == 12'h000 || q_primary_bus == 12'hfff) else $error("q flag on unclamped word");
  oclk_reset_low_a: assert property (oclk_rst_held |-> !i_output_clock && !q_output_clock)
    else $error("output clock not held low in reset");
  oclk_spacing_a: assert property ($changed(i_output_clock) |=> $stable(i_output_clock) [*2])
    else $error("i output clock toggles too fast");
  i_bus_clock_a: assert property ($changed(i_primary_bus) |-> $changed(i_output_clock))
    else $error("i word without clock edge");
  q_bus_clock_a: assert property ($changed(q_primary_bus) |-> $changed(q_output_clock))
    else $error("q word without clock edge");
endmodule

// file: verification/tb_adc_output_timing_and_calibration.sv
`timescale 1ns/1ps
`include "aotc_map.vh"
module tb_adc_output_timing_and_calibration;
  reg core_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [7:0] wb_adr_i = 8'h00;
  reg [31:0] wb_dat_i = 32'h0;
  reg [3:0] wb_sel_i = 4'hf;
  reg wb_we_i = 1'b0;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg sample_clk = 1'b0;
  reg [13:0] i_sample_in = 14'h0;
  reg [13:0] q_sample_in = 14'h0;
  reg start = 1'b0;
  reg i_power_down = 1'b0;
  reg q_power_down = 1'b0;
  reg cal_request = 1'b1;
  reg sclk_en = 1'b0;
  reg chk_on = 1'b0;
  reg last_oclk = 1'b0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, irq, i_output_clock, q_output_clock, i_out_of_range_flag, q_out_of_range_flag;
  wire cal_running, output_clock_reset, busy;
  wire [11:0] i_primary_bus, i_delayed_bus, q_primary_bus, q_delayed_bus;
  integer err_total = 0;
  integer n_checks = 0;
  integer cyc_cnt = 0;
  integer seed = 48455;
  integer k, r, s;
  logic [31:0] rq[$];
  logic [49:0] dq[$];
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #3;
    forever #40 sample_clk = sclk_en ? ~sample_clk : 1'b0;
  end
  aotc_top #(.CAL_DELAY_SELECT_LOW_CYC(16), .CAL_DELAY_SELECT_HIGH_CYC(32), .CAL_CYC(20)) aotc_top_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .sample_clk(sample_clk),
    .i_sample_in(i_sample_in), .q_sample_in(q_sample_in), .i_power_down(i_power_down), .q_power_down(q_power_down),
    .cal_delay_select(1'b0), .cal_request(cal_request), .output_clock_reset(output_clock_reset),
    .i_primary_bus(i_primary_bus), .i_delayed_bus(i_delayed_bus), .q_primary_bus(q_primary_bus),
    .q_delayed_bus(q_delayed_bus), .i_output_clock(i_output_clock), .q_output_clock(q_output_clock),
    .i_out_of_range_flag(i_out_of_range_flag), .q_out_of_range_flag(q_out_of_range_flag),
    .cal_running(cal_running));
  aotc_capture_model aotc_capture_model_inst (.core_clk(core_clk), .start(start),
    .output_clock_reset(output_clock_reset), .busy(busy));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [49:0] e, input logic [49:0] v);
    n_checks = n_checks + 1;
    if (v !== e) begin
      err_total = err_total + 1;
      $display("Error %s expected %h seen %h", what, e, v);
    end
  endtask
  function automatic logic [12:0] code_of(input logic [13:0] raw);
    integer v;
    v = $signed(raw) + 2048;
    if (v < 0) return 13'h1000;
    if (v > 4095) return 13'h1fff;
    return {1'b0, v[11:0]};
  endfunction
  task wb(input logic [7:0] a, input logic [31:0] d, input logic we, input logic [31:0] e);
    integer n;
    n = 0;
    if (!we) rq.push_back(e);
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i <= we;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n = n + 1;
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge core_clk);
  endtask
  task wait_until(input logic pick_busy, input logic lvl);
    integer n;
    n = 0;
    while ((pick_busy ? busy : cal_running) !== lvl && n < 3000) begin
      @(posedge core_clk);
      n = n + 1;
    end
  endtask
  task end_of_test;
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    last_oclk <= i_output_clock;
    cyc_cnt <= cyc_cnt + 1;
    if (chk_on && i_output_clock !== last_oclk && dq.size() > 0) check("output words", dq.pop_front(),
      {i_out_of_range_flag, i_primary_bus, q_out_of_range_flag, q_primary_bus, i_delayed_bus, q_delayed_bus});
    if (wb_ack_o && !wb_we_i && rq.size() > 0) check("register read", {18'h0, rq.pop_front()}, {18'h0, wb_dat_o});
    if (cyc_cnt == 40000) begin
      err_total = err_total + 1;
      $display("Error timeout expected done seen hang");
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    wb(`AOTC_REG_CTRL, 32'h0, 1'b0, 32'h2);
    wb(`AOTC_REG_GAIN_I, 32'h0, 1'b0, 32'h4000);
    wb(`AOTC_REG_GAIN_Q, 32'h0, 1'b0, 32'h4000);
    wb(`AOTC_REG_OFFS_Q, 32'h0, 1'b0, 32'h0);
    wb(`AOTC_REG_GAIN_I, 32'hffffffff, 1'b1, 32'h0);
    wb(`AOTC_REG_GAIN_I, 32'h0, 1'b0, 32'h7fff);
    wb(`AOTC_REG_OFFS_I, 32'hffffffff, 1'b1, 32'h0);
    wb(`AOTC_REG_OFFS_I, 32'h0, 1'b0, 32'h1fff);
    wb(8'h20, 32'hffffffff, 1'b1, 32'h0);
    wb(8'h20, 32'h0, 1'b0, 32'h0);
    wb(`AOTC_REG_CTRL, 32'h0, 1'b1, 32'h0);
    $display("Test registers done");
    sclk_en = 1'b1;
    wait_until(1'b0, 1'b1);
    wait_until(1'b0, 1'b0);
    wb(`AOTC_REG_STATUS, 32'h0, 1'b0, 32'h6);
    wb(`AOTC_REG_IRQ_STATUS, 32'h1f, 1'b1, 32'h0);
    repeat (40) @(posedge sample_clk);
    @(negedge sample_clk);
    @(posedge core_clk);
    chk_on <= 1'b1;
    repeat (34) dq.push_back({13'h0800, 13'h0800, 24'h0});
    for (k = 0; k < 100; k = k + 1) begin
      r = $random(seed);
      s = $random(seed);
      if (k >= 60) r = -2048;
      if (k >= 60) s = -2048;
      i_sample_in <= r[13:0];
      q_sample_in <= s[13:0];
      dq.push_back({code_of(r[13:0]), code_of(s[13:0]), 24'h0});
      @(negedge sample_clk);
      @(posedge core_clk);
    end
    repeat (36) @(posedge sample_clk);
    @(posedge core_clk);
    check("words left", 50'h0, dq.size());
    sclk_en = 1'b0;
    $display("Test stream done");
    wb(`AOTC_REG_IRQ_STATUS, 32'h0, 1'b0, 32'h3);
    wb(`AOTC_REG_IRQ_MASK, 32'h1, 1'b1, 32'h0);
    repeat (2) @(posedge core_clk);
    check("irq", 50'h1, {49'h0, irq});
    wb(`AOTC_REG_IRQ_MASK, 32'h0, 1'b1, 32'h0);
    repeat (2) @(posedge core_clk);
    check("irq", 50'h0, {49'h0, irq});
    wb(`AOTC_REG_IRQ_MASK, 32'h3, 1'b1, 32'h0);
    wb(`AOTC_REG_IRQ_STATUS, 32'h3, 1'b1, 32'h0);
    repeat (2) @(posedge core_clk);
    check("irq", 50'h0, {49'h0, irq});
    wb(`AOTC_REG_IRQ_STATUS, 32'h0, 1'b0, 32'h0);
    $display("Test interrupt done");
    i_power_down <= 1'b1;
    q_power_down <= 1'b1;
    repeat (5) @(posedge core_clk);
    wb(`AOTC_REG_STATUS, 32'h0, 1'b0, 32'h0);
    i_power_down <= 1'b0;
    q_power_down <= 1'b0;
    repeat (45) @(posedge core_clk);
    wb(`AOTC_REG_STATUS, 32'h0, 1'b0, 32'h0);
    repeat (10) @(posedge core_clk);
    wb(`AOTC_REG_STATUS, 32'h0, 1'b0, 32'h6);
    wb(`AOTC_REG_IRQ_STATUS, 32'h0, 1'b0, 32'h18);
    wb(`AOTC_REG_IRQ_STATUS, 32'h18, 1'b1, 32'h0);
    $display("Test power down done");
    sclk_en = 1'b1;
    cal_request <= 1'b0;
    repeat (1290) @(posedge sample_clk);
    @(posedge core_clk);
    cal_request <= 1'b1;
    repeat (1290) @(posedge sample_clk);
    @(posedge core_clk);
    wait_until(1'b0, 1'b0);
    sclk_en = 1'b0;
    wb(`AOTC_REG_IRQ_STATUS, 32'h0, 1'b0, 32'h4);
    $display("Test command calibration done");
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    wait_until(1'b1, 1'b1);
    wait_until(1'b1, 1'b0);
    check("output clocks", 50'h0, {48'h0, i_output_clock, q_output_clock});
    $display("Test clock reset done");
    end_of_test();
  end
endmodule
bind aotc_top aotc_checker aotc_checker_inst (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .output_clock_reset(output_clock_reset),
  .i_primary_bus(i_primary_bus), .q_primary_bus(q_primary_bus), .i_output_clock(i_output_clock),
  .q_output_clock(q_output_clock), .i_out_of_range_flag(i_out_of_range_flag),
  .q_out_of_range_flag(q_out_of_range_flag));
